// file: hdl/lmp_fetch_port.sv
// Purpose: Fetch-side local memory bus master port
// Assumes: Memory side answers with fetch_done and read data together
// Notes:   Read only; no lane selects, write data or write strobe
`timescale 1ns/1ps
module lmp_fetch_port (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Core side
    input  wire logic        req_valid,
    input  wire logic [31:0] req_addr,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [31:0]      rsp_data,
    // Local bus side
    output logic [31:0]      fetch_addr,
    output logic             fetch_xfer_strobe,
    output logic             fetch_in_progress,
    input  wire logic [31:0] fetch_rdata,
    input  wire logic        fetch_done
);

    lmp_pkg::lmp_state_e state_ff;
    lmp_pkg::lmp_state_e nxt_state;
    logic [31:0]         addr_ff;
    logic                strobe_ff;
    logic                rdy_ff;
    logic                busy_ff;
    logic                rv_ff;
    logic [31:0]         rd_ff;

    wire idle  = (state_ff == lmp_pkg::LMP_IDLE);
    wire start = idle && req_valid;
    wire fin   = !idle && fetch_done;

    always_comb begin
        case (state_ff)
            lmp_pkg::LMP_IDLE: nxt_state = start ? lmp_pkg::LMP_WAIT : lmp_pkg::LMP_IDLE;
            lmp_pkg::LMP_WAIT: nxt_state = fetch_done ? lmp_pkg::LMP_IDLE : lmp_pkg::LMP_WAIT;
            default:           nxt_state = lmp_pkg::LMP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= lmp_pkg::LMP_IDLE;
            addr_ff  <= 32'h0;
            strobe_ff <= 1'h0;
            rdy_ff   <= 1'h1;
            busy_ff  <= 1'h0;
            rv_ff    <= 1'h0;
            rd_ff    <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            strobe_ff <= start;
            rdy_ff   <= (nxt_state == lmp_pkg::LMP_IDLE);
            busy_ff  <= start || (busy_ff && !fin);
            addr_ff  <= start ? req_addr : 32'h0;
            rv_ff    <= fin;
            if (fin) begin
                rd_ff <= fetch_rdata;
            end
        end
    end

    assign req_ready         = rdy_ff;
    assign rsp_valid         = rv_ff;
    assign rsp_data          = rd_ff;
    assign fetch_addr        = addr_ff;
    assign fetch_xfer_strobe = strobe_ff;
    assign fetch_in_progress = busy_ff;

endmodule // lmp_fetch_port

// file: hdl/lmp_master_ports.sv
// Purpose: Processor-side master ports of the local memory bus
// Assumes: Core requests are synchronous to clock; one transfer per port
// Notes:   A request is launched registered, so the bus sees it one cycle
//          after it is taken; completion may come in that same cycle
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module lmp_master_ports #(
    // Bus geometry; the ports below are fixed at these values
    parameter int ADDR_W = lmp_pkg::ADDR_W,
    parameter int DATA_W = lmp_pkg::DATA_W,
    parameter int LANE_W = lmp_pkg::LANE_W
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Core data-side request
    input  wire logic        dreq_valid,
    input  wire logic        dreq_write,
    input  wire logic [1:0]  dreq_size,
    input  wire logic [31:0] dreq_addr,
    input  wire logic [31:0] dreq_wdata,
    output logic             dreq_ready,
    output logic             dreq_err,
    output logic             drsp_valid,
    output logic [31:0]      drsp_data,
    // Data-side local bus
    output logic [31:0]      dside_addr,
    output logic [3:0]       dside_lanes,
    output logic [31:0]      dside_wdata,
    output logic             dside_xfer_strobe,
    output logic             dside_rd_strobe,
    output logic             dside_wr_strobe,
    input  wire logic [31:0] dside_rdata,
    input  wire logic        dside_done,
    // Core fetch-side request
    input  wire logic        freq_valid,
    input  wire logic [31:0] freq_addr,
    output logic             freq_ready,
    output logic             frsp_valid,
    output logic [31:0]      frsp_data,
    // Fetch-side local bus
    output logic [31:0]      fetch_addr,
    output logic             fetch_xfer_strobe,
    output logic             fetch_in_progress,
    input  wire logic [31:0] fetch_rdata,
    input  wire logic        fetch_done,
    // Fetch-side peripheral constants
    output logic [31:0]      fetch_pbus_wdata,
    output logic             fetch_pbus_rnw
);

    // ------------------------------------------------------------
    // Geometry check
    // ------------------------------------------------------------
    // Steering and lane decode assume one 32-bit word of four byte
    // lanes; any other geometry is refused here rather than cut down.
    if (ADDR_W != $bits(dside_addr) || DATA_W != $bits(dside_wdata) ||
        LANE_W != $bits(dside_lanes)) begin : g_geometry_bad
        $error("lmp_master_ports supports only a 32-bit bus with four byte lanes");
    end

    // ------------------------------------------------------------
    // Lane decode and steering
    // ------------------------------------------------------------
    // Misaligned or oversized accesses decode to no lanes; the core
    // sees them refused so the bus never carries an odd code.
    function automatic logic [3:0] lane_code(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] r;
        r = lmp_pkg::LANES_NONE;
        case (sz)
            lmp_pkg::SIZE_BYTE: r = lmp_pkg::LANES_B0 >> a;
            lmp_pkg::SIZE_HALF: r = (a == 2'h0) ? lmp_pkg::LANES_H0 :
                                    (a == 2'h2) ? lmp_pkg::LANES_H1 : lmp_pkg::LANES_NONE;
            lmp_pkg::SIZE_WORD: r = (a == 2'h0) ? lmp_pkg::LANES_WORD : lmp_pkg::LANES_NONE;
            default:            r = lmp_pkg::LANES_NONE;
        endcase
        return r;
    endfunction

    wire [3:0]  req_lanes = lane_code(dreq_size, dreq_addr[1:0]);
    wire        req_bad   = (req_lanes == lmp_pkg::LANES_NONE);
    // Store data replicated so the low bytes sit in every enabled lane
    wire [31:0] wsteer    = (dreq_size == lmp_pkg::SIZE_BYTE) ? {4{dreq_wdata[7:0]}} :
                            (dreq_size == lmp_pkg::SIZE_HALF) ? {2{dreq_wdata[15:0]}} :
                            dreq_wdata;

    // ------------------------------------------------------------
    // Data-side port
    // ------------------------------------------------------------
    lmp_pkg::lmp_state_e dstate_ff;
    lmp_pkg::lmp_state_e nxt_dstate;
    logic [31:0] daddr_ff;
    logic [3:0]  dlanes_ff;
    logic [31:0] dwdata_ff;
    logic        das_ff;
    logic        drd_ff;
    logic        dwr_ff;
    logic        derr_ff;
    logic        drv_ff;
    logic [31:0] drd_data_ff;
    logic [3:0]  held_lanes_ff;
    logic [1:0]  held_size_ff;
    // Ready has a flop of its own so the core sees no decode behind it
    logic        dside_done_ff;

    wire didle   = (dstate_ff == lmp_pkg::LMP_IDLE);
    wire dstart  = didle && dreq_valid && !req_bad;
    // A refused request never reaches the bus; only the error pulse shows it
    wire dreject = didle && dreq_valid && req_bad;
    wire dfin    = !didle && dside_done;

    always_comb begin
        case (dstate_ff)
            lmp_pkg::LMP_IDLE: nxt_dstate = dstart ? lmp_pkg::LMP_WAIT : lmp_pkg::LMP_IDLE;
            lmp_pkg::LMP_WAIT: nxt_dstate = dside_done ? lmp_pkg::LMP_IDLE : lmp_pkg::LMP_WAIT;
            default:           nxt_dstate = lmp_pkg::LMP_IDLE;
        endcase
    end

    // Load data steered down from its lanes into the low bits
    wire [7:0]  rbyte = held_lanes_ff[3] ? dside_rdata[31:24] :
                        held_lanes_ff[2] ? dside_rdata[23:16] :
                        held_lanes_ff[1] ? dside_rdata[15:8]  : dside_rdata[7:0];
    wire [15:0] rhalf = held_lanes_ff[3] ? dside_rdata[31:16] : dside_rdata[15:0];
    wire [31:0] rsteer = (held_size_ff == lmp_pkg::SIZE_BYTE) ? {24'h0, rbyte} :
                         (held_size_ff == lmp_pkg::SIZE_HALF) ? {16'h0, rhalf} :
                         dside_rdata;

    always_ff @(posedge clock) begin
        if (rst) begin
            dstate_ff     <= lmp_pkg::LMP_IDLE;
            das_ff        <= 1'h0;
            drd_ff        <= 1'h0;
            dwr_ff        <= 1'h0;
            daddr_ff      <= 32'h0;
            dlanes_ff     <= lmp_pkg::LANES_NONE;
            dwdata_ff     <= 32'h0;
            derr_ff       <= 1'h0;
            drv_ff        <= 1'h0;
            drd_data_ff   <= 32'h0;
            held_lanes_ff <= lmp_pkg::LANES_NONE;
            held_size_ff  <= lmp_pkg::SIZE_BYTE;
            dside_done_ff     <= 1'h1;
        end else begin
            dstate_ff <= nxt_dstate;
            dside_done_ff <= (nxt_dstate == lmp_pkg::LMP_IDLE);
            das_ff    <= dstart;
            drd_ff    <= (dstart && !dreq_write) || (drd_ff && !dfin);
            dwr_ff    <= (dstart && dreq_write) || (dwr_ff && !dfin);
            // Location and lanes dropped after the first cycle
            daddr_ff  <= dstart ? dreq_addr : 32'h0;
            dlanes_ff <= dstart ? req_lanes : lmp_pkg::LANES_NONE;
            derr_ff   <= dreject;
            drv_ff    <= dfin && drd_ff;
            if (dstart) begin
                dwdata_ff     <= wsteer;
                held_lanes_ff <= req_lanes;
                held_size_ff  <= dreq_size;
            end
            if (dfin && drd_ff) begin
                drd_data_ff <= rsteer;
            end
        end
    end

    assign dreq_ready        = dside_done_ff;
    assign dreq_err          = derr_ff;
    assign drsp_valid        = drv_ff;
    assign drsp_data         = drd_data_ff;
    assign dside_addr        = daddr_ff;
    assign dside_lanes       = dlanes_ff;
    assign dside_wdata       = dwdata_ff;
    assign dside_xfer_strobe = das_ff;
    assign dside_rd_strobe   = drd_ff;
    assign dside_wr_strobe   = dwr_ff;

    // ------------------------------------------------------------
    // Fetch-side port and its peripheral-bus constants
    // ------------------------------------------------------------
    lmp_fetch_port u_fetch (
        .clock             (clock),
        .rst               (rst),
        .req_valid         (freq_valid),
        .req_addr          (freq_addr),
        .req_ready         (freq_ready),
        .rsp_valid         (frsp_valid),
        .rsp_data          (frsp_data),
        .fetch_addr        (fetch_addr),
        .fetch_xfer_strobe (fetch_xfer_strobe),
        .fetch_in_progress (fetch_in_progress),
        .fetch_rdata       (fetch_rdata),
        .fetch_done        (fetch_done)
    );

    // Constants kept as ports so both peripheral ports look alike
    assign fetch_pbus_wdata = lmp_pkg::FETCH_WDATA_CONST;
    assign fetch_pbus_rnw   = lmp_pkg::FETCH_RNW_CONST;

endmodule // lmp_master_ports

// file: hdl/lmp_pkg.sv
// Purpose: Shared constants for the local memory bus master ports
// Assumes: Single core clock, synchronous active-high reset
// Notes:   Lane 0 of a lane select is the most significant byte lane
package lmp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LANE_W = 4;

    // ------------------------------------------------------------
    // Lane select codes, bit 3 of the vector is lane 0 (MSB lane)
    // ------------------------------------------------------------
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [3:0] LANES_B3   = 4'h1;
    localparam logic [3:0] LANES_B2   = 4'h2;
    localparam logic [3:0] LANES_B1   = 4'h4;
    localparam logic [3:0] LANES_B0   = 4'h8;
    localparam logic [3:0] LANES_H1   = 4'h3;
    localparam logic [3:0] LANES_H0   = 4'hc;
    localparam logic [3:0] LANES_WORD = 4'hf;

    // ------------------------------------------------------------
    // Transfer sizes and constant outputs of the fetch-side bus port
    // ------------------------------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    localparam logic [31:0] FETCH_WDATA_CONST = 32'h0000_0000;
    localparam logic        FETCH_RNW_CONST   = 1'h1;

    // Port state: idle, or waiting for completion
    typedef enum logic [0:0] {
        LMP_IDLE = 1'h0,
        LMP_WAIT = 1'h1
    } lmp_state_e;

endpackage

// file: test/lmp_mem_model.sv
// Purpose: Block RAM controller model on one local memory bus port
// Assumes: Start strobe qualifies addr, lanes and write data
// Notes:   wait_n extra cycles before done; idle read data is inverted
`timescale 1ns/1ps
module lmp_mem_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Pacing
    input  wire logic [3:0]  wait_n,
    // Local bus
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  lanes,
    input  wire logic [31:0] wdata,
    input  wire logic        xfer,
    input  wire logic        wr,
    output logic [31:0]      rdata,
    output logic             done
);
    logic [31:0] mem [16];
    logic [31:0] last_ff, dat_ff;
    logic [3:0]  idx_ff, ln_ff, cnt_ff;
    logic        busy_ff, wr_ff;
    // Address and lanes trusted in the start cycle only
    wire  [3:0]  idx = xfer ? addr[5:2] : idx_ff;
    wire  [3:0]  ln  = xfer ? lanes : ln_ff;
    wire  [31:0] dat = xfer ? wdata : dat_ff;
    wire         w   = xfer ? wr : wr_ff;
    assign done  = xfer ? (wait_n == 4'h0) : (busy_ff && cnt_ff == 4'h0);
    assign rdata = done ? mem[idx] : ~last_ff;
    initial begin
        last_ff = 32'h0;
        for (int i = 0; i < 16; i++) mem[i] = 32'h0101_0101 * i;
    end
    always @(posedge clock) begin
        if (xfer) begin
            {idx_ff, ln_ff, dat_ff, wr_ff} <= {addr[5:2], lanes, wdata, wr};
            cnt_ff <= wait_n - 4'h1;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
        busy_ff <= !rst && (xfer ? wait_n != 4'h0 : busy_ff && cnt_ff != 4'h0);
        if (done) last_ff <= rdata;
        for (int b = 0; b < 4; b++) begin
            if (done && w && ln[b]) mem[idx][8*b +: 8] <= dat[8*b +: 8];
        end
    end
endmodule // lmp_mem_model

// file: test/lmp_properties.sv
// Purpose: Port timing checks for the local memory bus master ports
// Assumes: One clock, rst synchronous active high
// Notes:   Bound to the top module and sees its ports only
`timescale 1ns/1ps
module lmp_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Data side
    input wire logic        drsp_valid,
    input wire logic [31:0] dside_addr,
    input wire logic [3:0]  dside_lanes,
    input wire logic        dside_xfer_strobe,
    input wire logic        dside_rd_strobe,
    input wire logic        dside_wr_strobe,
    input wire logic        dside_done,
    // Fetch side
    input wire logic        frsp_valid,
    input wire logic        fetch_xfer_strobe,
    input wire logic        fetch_in_progress,
    input wire logic        fetch_done,
    input wire logic [31:0] fetch_pbus_wdata,
    input wire logic        fetch_pbus_rnw
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire busy = dside_rd_strobe || dside_wr_strobe;
    sequence d_wait; busy && !dside_done; endsequence
    sequence d_end; busy && dside_done; endsequence
    start_pulse_a: assert property (dside_xfer_strobe |=> !dside_xfer_strobe)
        else $error("data start strobe held");
    fetch_pulse_a: assert property (fetch_xfer_strobe |=> !fetch_xfer_strobe)
        else $error("fetch start strobe held");
    lane_code_a: assert property (dside_xfer_strobe |->
        dside_lanes inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
        else $error("illegal lane code");
    idle_quiet_a: assert property (!dside_xfer_strobe |->
        dside_addr == 32'h0 && dside_lanes == 4'h0)
        else $error("address or lanes outside start cycle");
    hold_busy_a: assert property (d_wait |=> busy && !dside_xfer_strobe)
        else $error("transfer dropped before done");
    drop_busy_a: assert property (d_end |=> !busy && !dside_xfer_strobe)
        else $error("strobe not dropped after done");
    busy_start_a: assert property ($rose(busy) |-> dside_xfer_strobe)
        else $error("in-progress without start");
    load_answer_a: assert property (dside_done && dside_rd_strobe |=> drsp_valid)
        else $error("load answer missing");
    fetch_hold_a: assert property (fetch_in_progress && !fetch_done |=>
        fetch_in_progress && !fetch_xfer_strobe)
        else $error("fetch dropped before done");
    fetch_answer_a: assert property (fetch_in_progress && fetch_done |=>
        frsp_valid && !fetch_in_progress)
        else $error("fetch answer missing");
    fetch_const_a: assert property (fetch_pbus_wdata == 32'h0 && fetch_pbus_rnw)
        else $error("fetch constants wrong");
endmodule // lmp_props

bind lmp_master_ports lmp_props u_props (.*);

// file: test/tb_top.sv
// Purpose: Self-checking bench for the local memory bus master ports
// Assumes: Inputs change on the falling edge; models answer both ports
// Notes:   Memory pacing is varied per scenario
`timescale 1ns/1ps
module tb_top;
    logic        clock, rst, dreq_valid, dreq_write, freq_valid, st, er, rv;
    logic [1:0]  dreq_size;
    logic [31:0] dreq_addr, dreq_wdata, freq_addr, q, ad;
    logic [3:0]  wait_d, wait_f, ln;
    wire         dreq_ready, dreq_err, drsp_valid, freq_ready, frsp_valid, dside_done;
    wire  [31:0] drsp_data, frsp_data, dside_addr, dside_wdata, dside_rdata;
    wire  [31:0] fetch_addr, fetch_rdata, fetch_pbus_wdata;
    wire  [3:0]  dside_lanes;
    wire         dside_xfer_strobe, dside_rd_strobe, dside_wr_strobe, fetch_pbus_rnw;
    wire         fetch_xfer_strobe, fetch_in_progress, fetch_done;
    int          fail_count, check_count;
    lmp_master_ports dut (.*);
    lmp_mem_model u_dmem (.clock(clock), .rst(rst), .wait_n(wait_d), .addr(dside_addr),
        .lanes(dside_lanes), .wdata(dside_wdata), .xfer(dside_xfer_strobe),
        .wr(dside_wr_strobe), .rdata(dside_rdata), .done(dside_done));
    lmp_mem_model u_fmem (.clock(clock), .rst(rst), .wait_n(wait_f), .addr(fetch_addr),
        .lanes(4'h0), .wdata(32'h0), .xfer(fetch_xfer_strobe), .wr(1'b0),
        .rdata(fetch_rdata), .done(fetch_done));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic d_op(input logic w, input logic [1:0] sz, input logic [31:0] a, d);
        dreq_valid = 1'b1;
        {dreq_write, dreq_size, dreq_addr, dreq_wdata} = {w, sz, a, d};
        @(negedge clock);
        dreq_valid = 1'b0;
        {st, ln, ad, er} = {dside_xfer_strobe, dside_lanes, dside_addr, dreq_err};
        for (int n = 0; n < 20 && dreq_ready !== 1'b1; n++) @(negedge clock);
        {rv, q} = {drsp_valid, drsp_data};
        @(negedge clock);
    endtask
    task automatic f_op(input logic [31:0] a);
        freq_valid = 1'b1;
        freq_addr = a;
        @(negedge clock);
        freq_valid = 1'b0;
        {st, ad} = {fetch_xfer_strobe, fetch_addr};
        for (int n = 0; n < 20 && freq_ready !== 1'b1; n++) @(negedge clock);
        {rv, q} = {frsp_valid, frsp_data};
        @(negedge clock);
    endtask
    task automatic t_reset();
        chk("ready", {dreq_ready, freq_ready}, 2'h3);
        chk("strobes", {dside_xfer_strobe, dside_rd_strobe, fetch_in_progress}, 3'h0);
        chk("idle bus", {fetch_xfer_strobe, dside_wr_strobe, dside_lanes}, 6'h0);
        chk("fetch wdata", fetch_pbus_wdata, 32'h0);
        chk("fetch rnw", fetch_pbus_rnw, 1'h1);
    endtask
    task automatic t_bytes();
        wait_d = 4'h0;
        for (int a = 0; a < 4; a++) begin
            d_op(1'b1, lmp_pkg::SIZE_BYTE, a, 32'h11 * (a + 1));
            chk("byte lanes", ln, 4'h8 >> a);
            chk("byte addr", ad, a);
        end
        d_op(1'b0, lmp_pkg::SIZE_WORD, 32'h0, 32'h0);
        chk("word lanes", ln, 4'hf);
        chk("word load", q, 32'h1122_3344);
        chk("load answer", rv, 1'b1);
        chk("load no err", er, 1'b0);
        d_op(1'b0, lmp_pkg::SIZE_BYTE, 32'h1, 32'h0);
        chk("lane 1 byte", q, 32'h0000_0022);
    endtask
    task automatic t_slow();
        wait_d = 4'h3;
        d_op(1'b1, lmp_pkg::SIZE_HALF, 32'h2, 32'h0000_beef);
        chk("low half lanes", ln, 4'h3);
        d_op(1'b1, lmp_pkg::SIZE_HALF, 32'h4, 32'h0000_cafe);
        chk("high half lanes", ln, 4'hc);
        d_op(1'b0, lmp_pkg::SIZE_WORD, 32'h4, 32'h0);
        chk("slow word", q, 32'hcafe_0101);
        d_op(1'b0, lmp_pkg::SIZE_HALF, 32'h4, 32'h0);
        chk("slow half", q, 32'h0000_cafe);
        d_op(1'b0, lmp_pkg::SIZE_BYTE, 32'h3, 32'h0);
        chk("slow byte", q, 32'h0000_00ef);
        chk("slow answer", rv, 1'b1);
    endtask
    task automatic t_refuse();
        d_op(1'b0, lmp_pkg::SIZE_HALF, 32'h1, 32'h0);
        chk("misaligned err", er, 1'b1);
        chk("misaligned quiet", st, 1'b0);
        d_op(1'b0, 2'h3, 32'h0, 32'h0);
        chk("bad size err", er, 1'b1);
    endtask
    task automatic t_fetch();
        for (int k = 0; k < 3; k += 2) begin
            wait_f = 4'(k);
            f_op(32'h8 + 4 * k);
            chk("fetch start", st, 1'b1);
            chk("fetch addr", ad, 32'h8 + 4 * k);
            // A monitor that ORs the write path onto read data still sees the word
            chk("fetch data", q | fetch_pbus_wdata, 32'h0101_0101 * (2 + k));
            chk("fetch answer", rv, 1'b1);
        end
    endtask
    // Both ports at once: the memory pair serves the two streams side by side
    task automatic t_both();
        {wait_d, wait_f} = 8'h20;
        {dreq_valid, dreq_write, dreq_size, dreq_addr} = {1'b1, 1'b0, lmp_pkg::SIZE_WORD, 32'h0};
        {freq_valid, freq_addr} = {1'b1, 32'hc};
        @(negedge clock);
        {dreq_valid, freq_valid} = 2'h0;
        chk("both start", {dside_xfer_strobe, fetch_xfer_strobe}, 2'h3);
        @(negedge clock);
        chk("fetch first", {frsp_valid, dreq_ready}, 2'h2);
        chk("fetch word", frsp_data, 32'h0303_0303);
        repeat (2) @(negedge clock);
        chk("load second", {drsp_valid, dreq_ready}, 2'h3);
        chk("load word", drsp_data, 32'h1122_beef);
        @(negedge clock);
    endtask
    // Reset in the middle of a slow load, then a load at the first edge after
    task automatic t_rst_mid();
        wait_d = 4'h3;
        {dreq_valid, dreq_write, dreq_size, dreq_addr} = {1'b1, 1'b0, lmp_pkg::SIZE_WORD, 32'h4};
        @(negedge clock);
        {dreq_valid, rst} = 2'b01;
        @(negedge clock);
        rst = 1'b0;
        chk("reset ready", dreq_ready, 1'b1);
        chk("reset quiet", {dside_xfer_strobe, dside_rd_strobe}, 2'h0);
        d_op(1'b0, lmp_pkg::SIZE_WORD, 32'h4, 32'h0);
        chk("after reset", q, 32'hcafe_0101);
        chk("after reset answer", rv, 1'b1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Hang guard at 5000 cycles, far beyond the fewer than a hundred cycles the run needs
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
    initial begin
        {rst, dreq_valid, dreq_write, freq_valid} = 4'h8;
        {dreq_size, dreq_addr, dreq_wdata, freq_addr} = '0;
        {wait_d, wait_f} = 8'h0;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        t_reset();
        t_bytes();
        t_slow();
        t_refuse();
        t_fetch();
        t_both();
        t_rst_mid();
        summarize();
    end
endmodule // tb_top
